// ==== core/uhwr_access.sv ====
// Purpose : Access check for one hardware register selector.
// Assumes : Mask bit index equals selector value.
// Notes   : Implementation flags come from the top-level parameters.
`include "uhwr_cfg.svh"

module uhwr_access #(
	parameter bit THREAD_PTR_IMPL = 1'b1,
	parameter bit IMPL_REGS_IMPL  = 1'b0,
	parameter bit [2:0] ARCH_REL  = 3'h2
) (
	input  wire logic [4:0]  sel_i,
	input  wire logic        cp0_enabled_i,
	input  wire logic [31:0] mask_i,
	output logic             allowed_o
);
	import uhwr_pkg::*;

	// Tells whether the selected register exists in this build.
	function automatic logic sel_implemented(input logic [4:0] sel);
		logic r;
		r = 1'b0;
		if (sel <= `UHWR_SEL_CYC_RES) begin
			r = 1'b1;
		end else if (sel >= `UHWR_SEL_RSV_LO && sel <= `UHWR_SEL_RSV_HI) begin
			r = 1'b0;
		end else if (sel == `UHWR_SEL_THREAD_PTR) begin
			r = THREAD_PTR_IMPL;
		end else begin
			r = IMPL_REGS_IMPL;
		end
		return r;
	endfunction : sel_implemented

	// ****************************************************************
	// Permission
	// ****************************************************************
	// Release-one cores treat the whole instruction as reserved.
	always_comb begin
		allowed_o = (ARCH_REL >= `UHWR_ARCH_REL_MIN) &&
		            sel_implemented(sel_i) &&
		            (cp0_enabled_i || mask_i[sel_i]);
	end

endmodule : uhwr_access

// ==== core/uhwr_cfg.svh ====
// Purpose : Constants for the user hardware register read unit.
// Assumes : Included by the package and by every design file of the unit.
// Notes   : Encodings, field positions, selector values and a few miscellaneous constants.
`ifndef UHWR_CFG_SVH
`define UHWR_CFG_SVH

// ****************************************************************
// Instruction encoding
// ****************************************************************
`define UHWR_OPC_MSB        31
`define UHWR_OPC_LSB        26
`define UHWR_OPC_EXT_GROUP  6'h1F
`define UHWR_FN_MSB         5
`define UHWR_FN_LSB         0
`define UHWR_FN_READ_HW     6'h3B
`define UHWR_RT_MSB         20
`define UHWR_RT_LSB         16
`define UHWR_SEL_MSB        15
`define UHWR_SEL_LSB        11

// ****************************************************************
// Hardware register selector values
// ****************************************************************
`define UHWR_SEL_CPU_NUM    5'h00
`define UHWR_SEL_SYNC_STEP  5'h01
`define UHWR_SEL_CYC_CNT    5'h02
`define UHWR_SEL_CYC_RES    5'h03
`define UHWR_SEL_RSV_LO     5'h04
`define UHWR_SEL_RSV_HI     5'h1C
`define UHWR_SEL_THREAD_PTR 5'h1D
`define UHWR_SEL_IMPL0      5'h1E
`define UHWR_SEL_IMPL1      5'h1F

// ****************************************************************
// Miscellaneous
// ****************************************************************
`define UHWR_CPU_NUM_W      10
`define UHWR_ARCH_REL_MIN   3'h2
`define UHWR_RESET_WORD     32'h0000_0000

`endif

// ==== core/uhwr_decode.sv ====
// Purpose : Field decode of an incoming instruction word.
// Assumes : Pure combinational; caller registers the outputs.
// Notes   : Only the register-read form is recognised.
`include "uhwr_cfg.svh"

module uhwr_decode (
	input  wire logic [31:0] instr_i,
	output logic             is_read_hw_o,
	output logic [4:0]       dest_gpr_field_o,
	output logic [4:0]       sel_o
);
	import uhwr_pkg::*;

	// ****************************************************************
	// Field extraction
	// ****************************************************************
	// Opcode group and function code must both match.
	always_comb begin
		is_read_hw_o     = (instr_i[`UHWR_OPC_MSB:`UHWR_OPC_LSB] == `UHWR_OPC_EXT_GROUP) &&
		                   (instr_i[`UHWR_FN_MSB:`UHWR_FN_LSB] == `UHWR_FN_READ_HW);
		dest_gpr_field_o = instr_i[`UHWR_RT_MSB:`UHWR_RT_LSB];
		sel_o            = instr_i[`UHWR_SEL_MSB:`UHWR_SEL_LSB];
	end

endmodule : uhwr_decode

// ==== core/uhwr_pkg.sv ====
// Purpose : Types shared by the user hardware register read unit.
// Assumes : uhwr_cfg.svh holds every numeric constant.
// Notes   : Structs carry the request and answer groups.
`include "uhwr_cfg.svh"

package uhwr_pkg;

	// ****************************************************************
	// Request and answer carriers
	// ****************************************************************
	typedef struct packed {
		logic        valid;
		logic [31:0] instr;
	} uhwr_req_t;

	typedef struct packed {
		logic        done;
		logic        wr_en;
		logic [4:0]  dest_gpr_field;
		logic [31:0] data;
		logic        rsv_instr_exc;
	} uhwr_rsp_t;

	// Privileged state seen by the unit.
	typedef struct packed {
		logic        cp0_enabled;
		logic [31:0] user_hw_access_mask;
		logic [9:0]  cpu_number;
		logic [31:0] cycle_counter;
		logic [31:0] thread_pointer_reg;
	} uhwr_cp0_t;

	typedef enum logic [1:0] {
		UHWR_ST_IDLE = 2'b00,
		UHWR_ST_EXEC = 2'b01,
		UHWR_ST_DONE = 2'b10
	} uhwr_state_t;

endpackage : uhwr_pkg

// ==== core/uhwr_unit.sv ====
// Purpose : Executes the user-mode hardware register read instruction.
// Assumes : Inputs synchronous to sys_clk_i; one request at a time.
// Notes   : Answer arrives two cycles after the request is taken.
`include "uhwr_cfg.svh"

// Summary of operation
// - On permitted access write selected register value to destination register.
// - Access is checked per register through the matching mask bit.
// - Permit when privileged access is enabled or the mask bit is set.
// - Denied or unimplemented reads raise reserved instruction, no write.
// - Selector 0 returns the processor number field.
// - Selector 1 returns cache sync stride, zero if no sync needed.
// - Selector 2 returns the cycle counter value.
// - Selector 3 returns cycles between counter updates.
// - Selectors 4 to 28 are reserved and raise reserved instruction.
// - Selector 29 returns thread pointer if implemented, else reserved.
// - Selectors 30 and 31 return implementation values or raise reserved.
// - First-release builds treat the whole instruction as reserved.
module uhwr_unit #(
	parameter bit          THREAD_PTR_IMPL = 1'b1,
	parameter bit          IMPL_REGS_IMPL  = 1'b0,
	parameter bit [2:0]    ARCH_REL        = 3'h2,
	parameter logic [31:0] SYNC_STRIDE     = 32'h0000_0020,
	parameter logic [31:0] CYC_RESOLUTION  = 32'h0000_0002,
	parameter logic [31:0] IMPL_VALUE0     = 32'h0000_0000,
	parameter logic [31:0] IMPL_VALUE1     = 32'h0000_0000
) (
	input  wire logic              sys_clk_i,
	input  wire logic              sys_rst_i,
	input  wire uhwr_pkg::uhwr_req_t req_i,
	input  wire uhwr_pkg::uhwr_cp0_t cp0_i,
	output logic                   req_ready_o,
	output uhwr_pkg::uhwr_rsp_t    rsp_o
);
	import uhwr_pkg::*;

	uhwr_state_t state_q;
	logic [31:0] instr_q;
	logic        is_read_hw;
	logic [4:0]  dest_gpr;
	logic [4:0]  sel;
	logic        allowed;
	logic [31:0] value;
	uhwr_rsp_t   rsp_q;

	// ****************************************************************
	// Decode and access check
	// ****************************************************************
	uhwr_decode u_decode (
		.instr_i          (instr_q),
		.is_read_hw_o     (is_read_hw),
		.dest_gpr_field_o (dest_gpr),
		.sel_o            (sel)
	);

	uhwr_access #(
		.THREAD_PTR_IMPL (THREAD_PTR_IMPL),
		.IMPL_REGS_IMPL  (IMPL_REGS_IMPL),
		.ARCH_REL        (ARCH_REL)
	) u_access (
		.sel_i         (sel),
		.cp0_enabled_i (cp0_i.cp0_enabled),
		.mask_i        (cp0_i.user_hw_access_mask),
		.allowed_o     (allowed)
	);

	// ****************************************************************
	// Value selection
	// ****************************************************************
	// Unlisted selectors give zero; they never reach the result anyway.
	always_comb begin
		value = `UHWR_RESET_WORD;
		case (sel)
			`UHWR_SEL_CPU_NUM:    value = {22'h000000, cp0_i.cpu_number};
			`UHWR_SEL_SYNC_STEP:  value = SYNC_STRIDE;
			`UHWR_SEL_CYC_CNT:    value = cp0_i.cycle_counter;
			`UHWR_SEL_CYC_RES:    value = CYC_RESOLUTION;
			`UHWR_SEL_THREAD_PTR: value = cp0_i.thread_pointer_reg;
			`UHWR_SEL_IMPL0:      value = IMPL_VALUE0;
			`UHWR_SEL_IMPL1:      value = IMPL_VALUE1;
			default:              value = `UHWR_RESET_WORD;
		endcase
	end

	// ****************************************************************
	// Sequencing
	// ****************************************************************
	// Holding the word one cycle keeps decode off the pipeline's path.
	assign req_ready_o = (state_q == UHWR_ST_IDLE);

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_q <= UHWR_ST_IDLE;
		end else begin
			case (state_q)
				UHWR_ST_IDLE: if (req_i.valid) begin
					state_q <= UHWR_ST_EXEC;
				end
				UHWR_ST_EXEC: state_q <= UHWR_ST_DONE;
				UHWR_ST_DONE: state_q <= UHWR_ST_IDLE;
				default:      state_q <= UHWR_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			instr_q <= `UHWR_RESET_WORD;
		end else if (state_q == UHWR_ST_IDLE && req_i.valid) begin
			instr_q <= req_i.instr;
		end
	end

	// ****************************************************************
	// Answer
	// ****************************************************************
	// A word that is not this instruction is also reported as reserved.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rsp_q <= '0;
		end else if (state_q == UHWR_ST_EXEC) begin
			rsp_q.done           <= 1'b1;
			rsp_q.dest_gpr_field <= dest_gpr;
			rsp_q.wr_en          <= is_read_hw && allowed;
			rsp_q.data           <= (is_read_hw && allowed) ? value : `UHWR_RESET_WORD;
			rsp_q.rsv_instr_exc  <= !(is_read_hw && allowed);
		end else begin
			rsp_q <= '0;
		end
	end

	assign rsp_o = rsp_q;

endmodule : uhwr_unit

// ==== tb/testbench.sv ====
// Purpose : Self-checking bench of the register read unit.
// Assumes : Design defaults; inputs change at the falling edge.
// Notes   : Each read is checked against the whole answer word.
bind uhwr_unit uhwr_unit_monitor uhwr_unit_monitor_inst (.sys_clk_i(sys_clk_i),
	.sys_rst_i(sys_rst_i), .req_i(req_i), .cp0_i(cp0_i), .req_ready_o(req_ready_o),
	.rsp_o(rsp_o));
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import uhwr_pkg::*;
	logic        sys_clk_i = 0;
	logic        sys_rst_i = 1;
	logic        en = 0;
	logic [31:0] mask = '0;
	uhwr_req_t   req = '0;
	uhwr_cp0_t   cp0;
	uhwr_rsp_t   rsp;
	logic        rdy;
	int          n_mismatch, samples_checked;
	// ****
	// Clock and instances
	// ****
	initial forever #50 sys_clk_i = ~sys_clk_i;
	uhwr_cp0_model uhwr_cp0_model_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.en_i(en), .mask_i(mask), .cp0_o(cp0));
	uhwr_unit uhwr_unit_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
		.cp0_i(cp0), .req_ready_o(rdy), .rsp_o(rsp));
	// One read: the counter is noted in the cycle where the unit samples it.
	task rd(logic [4:0] sel, logic ok, logic [5:0] fn = 6'h3B);
		logic [31:0] exp, cnt;
		uhwr_rsp_t   exp_rsp;
		@(negedge sys_clk_i);
		req = {1'b1, 6'h1F, 5'h00, ~sel, sel, 5'h00, fn};
		@(negedge sys_clk_i);
		req.valid = 1'b0;
		cnt = cp0.cycle_counter;
		samples_checked++;
		if (rdy !== 1'b0) begin
			n_mismatch++;
			$display("CHECK FAILED ready while busy exp 0 got %b", rdy);
		end
		// The answer stands for one cycle only, the second after the take.
		@(negedge sys_clk_i);
		case (sel)
			5'h00: exp = {22'h0, 10'h2A5};
			5'h01: exp = 32'h0000_0020;
			5'h02: exp = cnt;
			5'h03: exp = 32'h0000_0002;
			default: exp = 32'h1234_5678;
		endcase
		exp_rsp = {1'b1, ok, ~sel, ok ? exp : 32'h0, !ok};
		samples_checked++;
		if (rsp !== exp_rsp) begin
			n_mismatch++;
			$display("CHECK FAILED answer sel %0d exp %h got %h", sel, exp_rsp, rsp);
		end
	endtask : rd
	task t_values();
		en = 1;
		rd(5'h00, 1);
		rd(5'h01, 1);
		rd(5'h02, 1);
		rd(5'h03, 1);
		rd(5'h1D, 1);
		$display("test values done");
	endtask : t_values
	task t_mask();
		en = 0;
		mask = 32'h0000_0004;
		rd(5'h02, 1);
		rd(5'h03, 0);
		mask = 32'hFFFF_FFFF;
		rd(5'h1D, 1);
		rd(5'h04, 0);
		$display("test mask done");
	endtask : t_mask
	task t_reserved();
		en = 1;
		rd(5'h04, 0);
		rd(5'h1C, 0);
		rd(5'h1E, 0);
		rd(5'h1F, 0);
		rd(5'h00, 0, 6'h3A);
		$display("test reserved done");
	endtask : t_reserved
	task results();
		$display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	// Main sequence after a three-cycle reset.
	initial begin
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		sys_rst_i = 0;
		t_values();
		t_mask();
		t_reserved();
		results();
	end
	// Fourteen reads need about forty-five cycles; a hang stops well after.
	initial begin
		repeat (500) @(posedge sys_clk_i);
		n_mismatch++;
		results();
	end
endmodule : testbench

// ==== tb/uhwr_cp0_model.sv ====
// Purpose : Privileged state seen by the read unit.
// Assumes : Counter advances every second cycle.
// Notes   : Processor number and thread pointer are arbitrary.
module uhwr_cp0_model #(
	parameter logic [9:0]  CPU_NUM = 10'h2A5,
	parameter logic [31:0] TPTR    = 32'h1234_5678
) (
	input  wire logic          sys_clk_i,
	input  wire logic          sys_rst_i,
	input  wire logic          en_i,
	input  wire logic [31:0]   mask_i,
	output uhwr_pkg::uhwr_cp0_t cp0_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import uhwr_pkg::*;
	logic [31:0] cnt_q;
	logic        ph_q;
	// A running counter makes a stale sample show up as a wrong value.
	always_ff @(posedge sys_clk_i) begin
		ph_q <= sys_rst_i ? 1'b0 : !ph_q;
		cnt_q <= sys_rst_i ? 32'h0 : cnt_q + {31'h0, ph_q};
	end
	assign cp0_o = {en_i, mask_i, CPU_NUM, cnt_q, TPTR};
endmodule : uhwr_cp0_model

// ==== tb/uhwr_unit_monitor.sv ====
// Purpose : Protocol and result checks on the register read unit ports.
// Assumes : Default parameters (thread pointer on, slots 30/31 absent).
// Notes   : Bound into uhwr_unit from the testbench file.
module uhwr_unit_monitor (
	input wire logic                sys_clk_i,
	input wire logic                sys_rst_i,
	input wire uhwr_pkg::uhwr_req_t req_i,
	input wire uhwr_pkg::uhwr_cp0_t cp0_i,
	input wire logic                req_ready_o,
	input wire uhwr_pkg::uhwr_rsp_t rsp_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import uhwr_pkg::*;
	// ****
	// Request tracking
	// ****
	logic        taken, tk1_q, tk2_q, ok;
	logic [31:0] ins1_q, ins2_q;
	logic [4:0]  sel;
	uhwr_cp0_t   cp2_q;
	assign taken = req_i.valid && req_ready_o;
	assign sel = ins2_q[15:11];
	assign ok = ins2_q[31:26] == 6'h1F && ins2_q[5:0] == 6'h3B
		&& (cp2_q.cp0_enabled || cp2_q.user_hw_access_mask[sel])
		&& (sel < 5'h04 || sel == 5'h1D);
	// Follow a request to its answer; privileged state is frozen when sampled.
	always_ff @(posedge sys_clk_i) begin
		tk1_q <= !sys_rst_i && taken;
		tk2_q <= !sys_rst_i && tk1_q;
		ins1_q <= req_i.instr;
		ins2_q <= ins1_q;
		if (tk1_q) begin
			cp2_q <= cp0_i;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_answer_time: assert property (taken |-> ##2 rsp_o.done)
		else $error("answer not two cycles after request");
	a_busy_window: assert property (taken |=> !req_ready_o ##1 !req_ready_o ##1 req_ready_o)
		else $error("ready window wrong");
	a_quiet_idle: assert property (!rsp_o.done |-> rsp_o == '0)
		else $error("answer fields set without done");
	// The answer stands in the same cycle in which tk2_q is high.
	a_dest_field: assert property (tk2_q |-> rsp_o.dest_gpr_field == ins2_q[20:16])
		else $error("destination field wrong");
	a_permit_write: assert property (tk2_q && ok |-> rsp_o.wr_en && !rsp_o.rsv_instr_exc)
		else $error("permitted read not written");
	a_deny_exc: assert property (tk2_q && !ok |-> rsp_o.rsv_instr_exc && !rsp_o.wr_en)
		else $error("refused read without exception");
	a_cpu_value: assert property (tk2_q && ok && sel == 5'h00 |->
		rsp_o.data == {22'h0, cp2_q.cpu_number}) else $error("cpu number wrong");
	a_count_value: assert property (tk2_q && ok && sel == 5'h02 |->
		rsp_o.data == cp2_q.cycle_counter) else $error("cycle counter wrong");
	a_thread_value: assert property (tk2_q && ok && sel == 5'h1D |->
		rsp_o.data == cp2_q.thread_pointer_reg) else $error("thread pointer wrong");
	a_reserved_sel: assert property (tk2_q && sel > 5'h03 && sel < 5'h1D |->
		rsp_o.rsv_instr_exc) else $error("reserved selector answered");
	c_granted: cover property (tk2_q && ok);
	c_refused: cover property (tk2_q && !ok);
	c_counter: cover property (tk2_q && sel == 5'h02);
endmodule : uhwr_unit_monitor
